// ### bit_skid_buffer.sv
// two-entry buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
`include "serial_config_defines.svh"

module bit_skid_buffer
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic flush,
  input  wire logic in_valid,
  output logic      in_ready,
  input  wire logic in_data,
  output logic      out_valid,
  input  wire logic out_ready,
  output logic      out_data
);

  // ****************************************************************
  // storage and pointers
  // ****************************************************************
  logic [1:0] slot_r;   // the two entries
  logic       wr_ptr_r; // next slot to fill
  logic       rd_ptr_r; // next slot to drain
  logic [1:0] cnt_r;    // occupancy, 0..2
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_r != `BUF_CNT_FULL);
  assign out_valid = (cnt_r != `BUF_CNT_ZERO);
  assign out_data  = slot_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // write side
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      slot_r   <= 2'h0;
      wr_ptr_r <= `BUF_PTR_ZERO;
    end
    else if (flush)
      wr_ptr_r <= `BUF_PTR_ZERO;
    else if (push)
    begin
      slot_r[wr_ptr_r] <= in_data;
      wr_ptr_r         <= ~wr_ptr_r;
    end
  end

  // read side
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || flush)
      rd_ptr_r <= `BUF_PTR_ZERO;
    else if (pop)
      rd_ptr_r <= ~rd_ptr_r;
  end

  // occupancy; flush drops anything held so a restart begins clean
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || flush)
      cnt_r <= `BUF_CNT_ZERO;
    else if (push && !pop)
      cnt_r <= cnt_r + `BUF_CNT_ONE;
    else if (pop && !push)
      cnt_r <= cnt_r - `BUF_CNT_ONE;
  end

endmodule // bit_skid_buffer

// ### config_bit_store.sv
// flip-flop array standing for the nonvolatile configuration memory
`timescale 1ns/1ps
`include "serial_config_defines.svh"

module config_bit_store
(
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic [`CFG_ADDR_W-1:0] rd_addr,
  output logic                        rd_bit
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [`CFG_DEPTH-1:0] mem_r;   // one flop per stored bit
  localparam logic [`CFG_DEPTH-1:0] INIT_IMAGE = `CFG_INIT_IMAGE;

  // each entry reloads its programmed value at reset; nothing writes it later,
  // which is how a one-time programmed array behaves from the outside
  generate
    for (genvar i = 0; i < `CFG_DEPTH; i++)
    begin : g_entry
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          mem_r[i] <= INIT_IMAGE[i];
        else
          mem_r[i] <= mem_r[i];
      end
    end
  endgenerate

  // indexed read; addresses past the end read zero
  always_comb
  begin
    if (rd_addr <= `CFG_LAST_ADDR)
      rd_bit = mem_r[rd_addr[`CFG_ADDR_W-2:0]];
    else
      rd_bit = 1'b0;
  end

endmodule // config_bit_store

// ### config_target_model.sv
// behavioural model of the logic device that receives the serial bitstream
`timescale 1ns/1ps
`include "serial_config_defines.svh"

module config_target_model
(
  input  wire logic                 shift_clk,
  input  wire logic                 data_line,
  input  wire logic                 data_oe,
  input  wire logic                 clear,
  output logic                      target_scheme_sel_lo,
  output logic                      target_scheme_sel_hi,
  output logic [`CFG_DEPTH-1:0]     captured,
  output logic [7:0]                count
);
  // ****************************************************************
  // scheme selects: passive serial needs both tied low
  // ****************************************************************
  assign target_scheme_sel_lo = 1'b0;
  assign target_scheme_sel_hi = 1'b0;

  // ****************************************************************
  // capture on shift rise, first bit into bit 0
  // ****************************************************************
  // a floating data line carries nothing, so undriven rises are skipped
  always @(posedge shift_clk or posedge clear)
  begin
    if (clear)
    begin
      captured <= '0;
      count    <= 8'h00;
    end
    else if (data_oe === 1'b1)
    begin
      captured[count[5:0]] <= data_line;
      count                <= count + 8'h01;
    end
  end

endmodule // config_target_model

// ### serial_config_checker.sv
// concurrent assertions watching the pins of the serial configuration source
`timescale 1ns/1ps

module serial_config_checker
  import serial_config_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          resetn,
  input wire logic                          oe_in,
  input wire logic                          cs_n_in,
  input wire logic                          dclk_out,
  input wire logic                          dclk_oe,
  input wire logic                          target_serial_in,
  input wire logic                          target_serial_oe,
  input wire logic                          cascade_out_n,
  input wire serial_config_pkg::chain_role_t role
);
  // ****************************************************************
  // one clock domain, synchronous reset
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // properties
  // ****************************************************************
  // six cycles cover both synchroniser stages and the output register
  property p_float_deselected;
    cs_n_in [*6] |-> !target_serial_oe;
  endproperty
  a_float_deselected: assert property (p_float_deselected)
    else $error("data driven while deselected");

  property p_float_done;
    !cascade_out_n |-> !target_serial_oe;
  endproperty
  a_float_done: assert property (p_float_done)
    else $error("data driven after end of data");

  property p_first_drives_clk;
    role == ROLE_FIRST ##1 role == ROLE_FIRST |-> dclk_oe;
  endproperty
  a_first_drives_clk: assert property (p_first_drives_clk)
    else $error("first device not driving shift clock");

  property p_subseq_takes_clk;
    role == ROLE_SUBSEQUENT ##1 role == ROLE_SUBSEQUENT |-> !dclk_oe;
  endproperty
  a_subseq_takes_clk: assert property (p_subseq_takes_clk)
    else $error("subsequent device driving shift clock");

  property p_clk_low_done;
    !cascade_out_n [*5] |-> !dclk_out;
  endproperty
  a_clk_low_done: assert property (p_clk_low_done)
    else $error("shift clock running after end of data");

  property p_oe_low_resets;
    !oe_in [*4] |-> !dclk_out && !target_serial_oe && cascade_out_n;
  endproperty
  a_oe_low_resets: assert property (p_oe_low_resets)
    else $error("output-enable low did not reset and float");

  property p_drive_needs_enable;
    target_serial_oe |-> $past(oe_in, 3) && !$past(cs_n_in, 3);
  endproperty
  a_drive_needs_enable: assert property (p_drive_needs_enable)
    else $error("data driven without enable and select");

  // a new bit is launched by the same edge that raises the generated shift clock
  property p_bit_after_rise;
    role == ROLE_FIRST && target_serial_oe && $past(target_serial_oe) && $changed(target_serial_in)
      |-> $rose(dclk_out);
  endproperty
  a_bit_after_rise: assert property (p_bit_after_rise)
    else $error("data changed away from a shift rise");

  property p_low_phase;
    $fell(dclk_out) |-> !dclk_out [*4];
  endproperty
  a_low_phase: assert property (p_low_phase)
    else $error("shift clock low phase too short");

endmodule // serial_config_checker

// ### serial_config_defines.svh
// constants for the serial configuration bitstream source
`ifndef SERIAL_CONFIG_DEFINES_SVH
`define SERIAL_CONFIG_DEFINES_SVH

// ****************************************************************
// stored bitstream geometry
// ****************************************************************
`define CFG_DEPTH        64
`define CFG_ADDR_W       7
`define CFG_LAST_ADDR    7'h3F
`define CFG_FIRST_ADDR   7'h00
`define CFG_ADDR_STEP    7'h01
`define CFG_INIT_IMAGE   64'hA5C3_0FF0_3C96_5AE1

// ****************************************************************
// oscillator timing, 100 MHz reference clock
// ****************************************************************
`define REF_CLK_PERIOD_NS 10
`define OSC_HALF_NS       40
`define OSC_HALF_CYCLES   (`OSC_HALF_NS / `REF_CLK_PERIOD_NS)
`define OSC_DIV_W         4
`define OSC_DIV_ZERO      4'h0
`define OSC_DIV_ONE       4'h1

// ****************************************************************
// buffer geometry
// ****************************************************************
`define BUF_PTR_ZERO      1'h0
`define BUF_CNT_ZERO      2'h0
`define BUF_CNT_ONE       2'h1
`define BUF_CNT_FULL      2'h2

`endif

// ### serial_config_pkg.sv
// types shared by the serial configuration bitstream source
package serial_config_pkg;

  // ****************************************************************
  // chain role, caught while the output-enable pin holds reset
  // ****************************************************************
  typedef enum logic {
    ROLE_FIRST,
    ROLE_SUBSEQUENT
  } chain_role_t;

  // ****************************************************************
  // shift sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SHIFT,
    SEQ_DONE
  } seq_state_t;

endpackage

// ### serial_config_source.sv
// serial configuration bitstream source: counter, oscillator, pins
//
// Behaviour
// - data floats while select is high beforehand
// - data floats after all data sent
// - first/single device drives shift clock out
// - subsequent device takes shift clock in
// - rising shift edge advances counter, next bit
// - count only when enabled, selected, unfinished
// - first device holds clock low when idle
// - output-enable low resets the address counter
// - output-enable high enables data and counting
// - output-enable low stops oscillator, clock low
// - select low permits counting and data drive
// - select low at reset: first device
// - select high at reset: subsequent device
// - nonvolatile array shifted out by oscillator (first) or by shift clock in (subsequent)
// - cascade output low at counter maximum
// - output-enable low again resets and floats
// - after cascade low, data output floats
`timescale 1ns/1ps
`include "serial_config_defines.svh"

module serial_config_source
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic oe_in,
  output logic      oe_out,
  output logic      oe_oe,
  input  wire logic cs_n_in,
  input  wire logic dclk_in,
  output logic      dclk_out,
  output logic      dclk_oe,
  output logic      target_serial_in,
  output logic      target_serial_oe,
  output logic      cascade_out_n,
  output serial_config_pkg::chain_role_t role
);
  // role and sequencer types come from the shared package
  import serial_config_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic       oe_meta_r;      // first stage, read only by the second
  logic       oe_sync_r;      // output-enable, safe to use
  logic       cs_meta_r;      // first stage
  logic       cs_sync_r;      // select (active low), safe to use
  logic       dclk_meta_r;    // first stage
  logic       dclk_sync_r;    // shift clock in, safe to use
  logic       dclk_prev_r;    // last value for edge detect

  // every pin is asynchronous to ref_clk, so each gets two flops
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      oe_meta_r   <= 1'b0;
      oe_sync_r   <= 1'b0;
      cs_meta_r   <= 1'b1;
      cs_sync_r   <= 1'b1;
      dclk_meta_r <= 1'b0;
      dclk_sync_r <= 1'b0;
      dclk_prev_r <= 1'b0;
    end
    else
    begin
      oe_meta_r   <= oe_in;
      oe_sync_r   <= oe_meta_r;
      cs_meta_r   <= cs_n_in;
      cs_sync_r   <= cs_meta_r;
      dclk_meta_r <= dclk_in;
      dclk_sync_r <= dclk_meta_r;
      dclk_prev_r <= dclk_sync_r;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  chain_role_t             role_r;        // chain position
  seq_state_t              seq_r;         // sequencer state
  seq_state_t              seq_nxt;
  logic [`CFG_ADDR_W-1:0]  addr_r;        // index of bit on the pin
  logic [`CFG_ADDR_W-1:0]  fetch_addr_r;  // next bit to prefetch
  logic [`OSC_DIV_W-1:0]   div_r;         // oscillator divider
  logic                    dclk_out_r;    // generated shift clock
  logic                    dclk_oe_r;
  logic                    data_r;        // bit on the data pin
  logic                    data_oe_r;
  logic                    casc_n_r;
  logic                    enabled;       // oe high, selected, not done
  logic                    osc_run;       // oscillator permitted
  logic                    int_rise;      // generated clock about to rise
  logic                    ext_rise;      // rising edge of incoming clock
  logic                    shift_edge;    // rise that applies to this role
  logic                    store_bit;
  logic                    buf_in_ready;
  logic                    buf_out_valid;
  logic                    buf_out_data;
  logic                    pop;
  logic                    fetch_valid;

  localparam logic [`OSC_DIV_W-1:0] OSC_HALF = `OSC_DIV_W'(`OSC_HALF_CYCLES);

  // counting needs oe high, select low and data left to send
  assign enabled    = oe_sync_r & ~cs_sync_r & (seq_r != SEQ_DONE);
  assign osc_run    = enabled & (role_r == ROLE_FIRST);
  assign int_rise   = osc_run & (div_r == OSC_HALF - `OSC_DIV_ONE) & ~dclk_out_r;
  assign ext_rise   = dclk_sync_r & ~dclk_prev_r;
  // the prefetch buffer must hold a bit when an edge arrives; the oscillator
  // is far slower than the fetch path so it never runs dry in practice
  assign shift_edge = enabled & ((role_r == ROLE_FIRST) ? int_rise : ext_rise);

  // ****************************************************************
  // chain role capture
  // ****************************************************************
  // role follows select while oe holds the device in reset, and freezes
  // on release; a flop, not the pin, is loaded so reset stays constant
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      role_r <= ROLE_FIRST;
    else if (!oe_sync_r)
      role_r <= cs_sync_r ? ROLE_SUBSEQUENT : ROLE_FIRST;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb
  begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_IDLE:
      begin
        // first bit is presented as soon as the device is selected
        if (enabled && buf_out_valid)
          seq_nxt = SEQ_SHIFT;
      end
      SEQ_SHIFT:
      begin
        if (shift_edge && addr_r == `CFG_LAST_ADDR)
          seq_nxt = SEQ_DONE;
      end
      SEQ_DONE:
        seq_nxt = SEQ_DONE;
      default:
        seq_nxt = SEQ_IDLE;
    endcase
    if (!oe_sync_r)
      seq_nxt = SEQ_IDLE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      seq_r <= SEQ_IDLE;
    else
      seq_r <= seq_nxt;
  end

  // ****************************************************************
  // address counter
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !oe_sync_r)
      addr_r <= `CFG_FIRST_ADDR;
    else if (seq_r == SEQ_SHIFT && shift_edge && addr_r != `CFG_LAST_ADDR)
      addr_r <= addr_r + `CFG_ADDR_STEP;
  end

  // ****************************************************************
  // prefetch from the array into the buffer
  // ****************************************************************
  assign fetch_valid = oe_sync_r & (fetch_addr_r <= `CFG_LAST_ADDR);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !oe_sync_r)
      fetch_addr_r <= `CFG_FIRST_ADDR;
    else if (fetch_valid && buf_in_ready)
      fetch_addr_r <= fetch_addr_r + `CFG_ADDR_STEP;
  end

  config_bit_store config_bit_store_inst
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .rd_addr (fetch_addr_r),
    .rd_bit  (store_bit)
  );

  // pops: the first bit on entering shift, then one per edge before the end
  assign pop = buf_out_valid &
               (((seq_r == SEQ_IDLE) && enabled) ||
                ((seq_r == SEQ_SHIFT) && shift_edge && addr_r != `CFG_LAST_ADDR));

  // stalls upstream fetch when full, so no bit is dropped
  bit_skid_buffer bit_skid_buffer_inst
  (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .flush     (~oe_sync_r),
    .in_valid  (fetch_valid),
    .in_ready  (buf_in_ready),
    .in_data   (store_bit),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (buf_out_data)
  );

  // ****************************************************************
  // data pin
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      data_r <= 1'b0;
    else if (pop)
      data_r <= buf_out_data;
  end

  // drives only while oe high, select low, shifting and not finished
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      data_oe_r <= 1'b0;
    else
      data_oe_r <= (seq_nxt == SEQ_SHIFT) & ~cs_sync_r & oe_sync_r;
  end

  // ****************************************************************
  // cascade output
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      casc_n_r <= 1'b1;
    else
      casc_n_r <= (seq_nxt != SEQ_DONE);
  end

  // ****************************************************************
  // oscillator and shift clock pin
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !osc_run)
    begin
      div_r      <= `OSC_DIV_ZERO;
      dclk_out_r <= 1'b0;
    end
    else if (div_r == OSC_HALF - `OSC_DIV_ONE)
    begin
      div_r      <= `OSC_DIV_ZERO;
      dclk_out_r <= ~dclk_out_r;
    end
    else
      div_r <= div_r + `OSC_DIV_ONE;
  end

  // pin direction follows the captured role
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      dclk_oe_r <= 1'b0;
    else
      dclk_oe_r <= (role_r == ROLE_FIRST);
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the error-detect pull-down on oe is not modelled: never driven
  assign oe_out           = 1'b0;
  assign oe_oe            = 1'b0;
  assign dclk_out         = dclk_out_r;
  assign dclk_oe          = dclk_oe_r;
  assign target_serial_in = data_r;
  assign target_serial_oe = data_oe_r;
  assign cascade_out_n    = casc_n_r;
  assign role             = role_r;

endmodule // serial_config_source

// ### tb_serial_config_bitstream_source.sv
// self-checking testbench for the serial configuration bitstream source
`timescale 1ns/1ps
`include "serial_config_defines.svh"

module tb_serial_config_bitstream_source;
  import serial_config_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic                  ref_clk;
  logic                  resetn;
  logic                  oe_in;
  logic                  cs_n_in;
  logic                  tb_dclk;     // shift clock we drive in subsequent role
  logic                  clear;
  logic                  dclk_out;
  logic                  dclk_oe;
  logic                  target_serial_in;
  logic                  target_serial_oe;
  logic                  cascade_out_n;
  logic                  oe_pin_out;  // open-drain pull-down level on oe
  logic                  oe_pin_oe;   // open-drain pull-down enable on oe
  chain_role_t           role;
  wire                   shift_clk;
  wire                   data_dly;    // wire delay gives the receiver hold time
  wire                   oe_dly;
  logic [`CFG_DEPTH-1:0] captured;
  logic [7:0]            rx_count;
  int                    miscompares;
  int                    n_checks;

  assign shift_clk = (dclk_oe === 1'b1) ? dclk_out : tb_dclk;
  // a released data line shows the inverse so a sample taken while floating shows up
  assign #2 data_dly = (target_serial_oe === 1'b1) ? target_serial_in : ~target_serial_in;
  assign #2 oe_dly = target_serial_oe;

  // ****************************************************************
  // instances
  // ****************************************************************
  serial_config_source serial_config_source_inst
  (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .oe_in            (oe_in),
    .oe_out           (oe_pin_out),
    .oe_oe            (oe_pin_oe),
    .cs_n_in          (cs_n_in),
    .dclk_in          (shift_clk),
    .dclk_out         (dclk_out),
    .dclk_oe          (dclk_oe),
    .target_serial_in (target_serial_in),
    .target_serial_oe (target_serial_oe),
    .cascade_out_n    (cascade_out_n),
    .role             (role)
  );

  config_target_model config_target_model_inst
  (
    .shift_clk            (shift_clk),
    .data_line            (data_dly),
    .data_oe              (oe_dly),
    .clear                (clear),
    .target_scheme_sel_lo (),
    .target_scheme_sel_hi (),
    .captured             (captured),
    .count                (rx_count)
  );

  // ****************************************************************
  // clock, helpers
  // ****************************************************************
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // bounded waits: a hang counts as a mismatch instead of stalling
  task automatic wait_rx(input logic [7:0] n, input int lim);
    int i;
    for (i = 0; i < lim && !(rx_count >= n); i++)
      @(negedge ref_clk);
    check(64'(i < lim), 64'h1);
  endtask

  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim && cascade_out_n !== 1'b0; i++)
      @(negedge ref_clk);
    check(64'(i < lim), 64'h1);
  endtask

  // rising edges eight cycles apart, clock rests low afterwards
  task automatic pulse(input int n);
    repeat (n)
    begin
      tb_dclk = 1'b1;
      tick(4);
      tb_dclk = 1'b0;
      tick(4);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_deselected;
    oe_in = 1'b1;
    cs_n_in = 1'b1;
    tick(30);
    check(64'(target_serial_oe), 64'h0);
    check(64'(rx_count), 64'h0);
  endtask

  // select, then pull output-enable low mid-stream after ten bits
  task automatic t_abort;
    cs_n_in = 1'b0;
    wait_rx(8'h0A, 400);
    oe_in = 1'b0;
    tick(8);
    check(64'(dclk_out), 64'h0);
    check(64'(target_serial_oe), 64'h0);
    check(64'(cascade_out_n), 64'h1);
    check(64'(dclk_oe), 64'h1);
  endtask

  // restart must begin again at bit 0 and end after the last bit
  task automatic t_full_first;
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
    oe_in = 1'b1;
    wait_done(1000);
    tick(20);
    check(captured, `CFG_INIT_IMAGE);
    check(64'(rx_count), 64'(`CFG_DEPTH));
    check(64'(target_serial_oe), 64'h0);
    check(64'(dclk_out), 64'h0);
    check(64'(oe_pin_oe), 64'h0);
    check(64'(oe_pin_out), 64'h0);
  endtask

  task automatic t_subsequent;
    oe_in = 1'b0;
    cs_n_in = 1'b1;
    tick(10);
    check(64'(role), 64'(ROLE_SUBSEQUENT));
    check(64'(dclk_oe), 64'h0);
    check(64'(cascade_out_n), 64'h1);
    oe_in = 1'b1;
    pulse(5);
    check(64'(target_serial_oe), 64'h0);
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
    cs_n_in = 1'b0;
    tick(20);
    pulse(64);
    tick(10);
    check(captured, `CFG_INIT_IMAGE);
    check(64'(cascade_out_n), 64'h0);
    pulse(3);
    check(64'(target_serial_oe), 64'h0);
    check(64'(rx_count), 64'(`CFG_DEPTH));
  endtask

  // ****************************************************************
  // verdict, watchdog, main sequence
  // ****************************************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // whole run needs under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    resetn = 1'b0;
    oe_in = 1'b0;
    cs_n_in = 1'b0;
    tb_dclk = 1'b0;
    clear = 1'b1;
    miscompares = 0;
    n_checks = 0;
    tick(5);
    resetn = 1'b1;
    clear = 1'b0;
    tick(6);
    check(64'(role), 64'(ROLE_FIRST));
    check(64'(dclk_oe), 64'h1);
    t_deselected();
    t_abort();
    t_full_first();
    t_subsequent();
    report_and_stop();
  end

endmodule // tb_serial_config_bitstream_source

bind serial_config_source serial_config_checker serial_config_checker_inst
(
  .ref_clk          (ref_clk),
  .resetn           (resetn),
  .oe_in            (oe_in),
  .cs_n_in          (cs_n_in),
  .dclk_out         (dclk_out),
  .dclk_oe          (dclk_oe),
  .target_serial_in (target_serial_in),
  .target_serial_oe (target_serial_oe),
  .cascade_out_n    (cascade_out_n),
  .role             (role)
);
